//--- src/aso_pkg.sv
// shared constants and types for the serial control block
package aso_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF   = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0C;
  localparam logic [7:0] BAUD_OFF   = 8'h10;
  localparam logic [7:0] EVENT_OFF  = 8'h14;
  // status and event bit positions
  localparam int TX_DATA_EMPTY_FLAG_BIT = 0;
  localparam int TC_BIT   = 1;
  localparam int RX_FULL_FLAG_BIT = 2;
  localparam int OVR_BIT  = 3;
  localparam int IDLE_BIT = 4;
  localparam int PERR_BIT = 5;
  localparam int EV_W     = 5;
  // reset values
  localparam logic [12:0] CTRL_RST  = 13'h0000;
  localparam logic [15:0] BAUD_RST  = 16'h0043;
  localparam logic [4:0]  MASK_RST  = 5'h1F;
  // frame timing in oversample ticks, frame lengths in bits
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_MID       = 4'h7;
  localparam logic [3:0] BITS_SHORT      = 4'hA;
  localparam logic [3:0] BITS_LONG       = 4'hB;
  localparam logic [7:0] IDLE_SHORT      = 8'hA0;
  localparam logic [7:0] IDLE_LONG       = 8'hB0;

  // control register, bit 12 down to bit 0
  typedef struct packed {
    logic addr_mark_rouse;
    logic data_nine_bits;
    logic idle_detect_long;
    logic parity_odd_select;
    logic parity_on;
    logic tx_empty_irq_on;
    logic tx_done_irq_on;
    logic rx_full_irq_on;
    logic idle_irq_on;
    logic tx_on;
    logic rx_on;
    logic rx_sleep;
    logic send_break_req;
  } aso_ctrl_type;

  // frame format passed to the transmit shifter
  typedef struct packed {
    logic nine;
    logic par_on;
    logic par_odd;
  } aso_fmt_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } aso_rx_state_type;
endpackage

//--- src/aso_baud.sv
// oversample tick divider
`timescale 1ns/10ps
`default_nettype none
module aso_baud (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // divisor and tick
  input  wire logic [15:0] divisor,
  output logic             tick16
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  always_comb begin
    if (cnt_reg >= divisor) begin
      cnt_next = 16'h0000;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick16 = (cnt_reg >= divisor);
endmodule // aso_baud
`default_nettype wire

//--- src/aso_tx.sv
// transmit shifter with parity and break frames
`timescale 1ns/10ps
`default_nettype none
module aso_tx (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // timing and format
  input  wire logic                 tick16,
  input  wire aso_pkg::aso_fmt_type fmt,
  // frame request
  input  wire logic                 start,
  input  wire logic                 brk,
  input  wire logic [8:0]           data,
  // line side
  output logic                      busy,
  output logic                      line
);
  logic [10:0] sh_reg, sh_next;
  logic [3:0]  bit_reg, bit_next;
  logic [3:0]  sub_reg, sub_next;
  logic [3:0]  len_reg, len_next;
  logic        busy_reg, busy_next;
  logic [8:0]  pay;
  logic        par;

  always_comb begin
    pay = fmt.nine ? data : {1'b0, data[7:0]};
    par = fmt.nine ? ^data[7:0] : ^data[6:0];
    par = par ^ fmt.par_odd;
    if (fmt.par_on) begin
      if (fmt.nine) begin
        pay[8] = par;
      end else begin
        pay[7] = par;
      end
    end
    sh_next   = sh_reg;
    bit_next  = bit_reg;
    sub_next  = sub_reg;
    len_next  = len_reg;
    busy_next = busy_reg;
    if (!busy_reg) begin
      if (start) begin
        busy_next = 1'b1;
        bit_next  = 4'h0;
        sub_next  = 4'h0;
        len_next  = fmt.nine ? aso_pkg::BITS_LONG : aso_pkg::BITS_SHORT;
        if (fmt.nine) begin
          sh_next = {1'b1, pay, 1'b0};
        end else begin
          sh_next = {1'b1, 1'b1, pay[7:0], 1'b0};
        end
        if (brk) begin
          sh_next = 11'h000;
        end
      end
    end else if (tick16) begin
      sub_next = sub_reg + 4'h1;
      if (sub_reg == aso_pkg::OVERSAMPLE_LAST) begin
        sh_next  = {1'b1, sh_reg[10:1]};
        bit_next = bit_reg + 4'h1;
        if (bit_reg == len_reg - 4'h1) begin
          busy_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_reg   <= 11'h7FF;
      bit_reg  <= 4'h0;
      sub_reg  <= 4'h0;
      len_reg  <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      bit_reg  <= bit_next;
      sub_reg  <= sub_next;
      len_reg  <= len_next;
      busy_reg <= busy_next;
    end
  end

  assign line = busy_reg ? sh_reg[0] : 1'b1;
  assign busy = busy_reg;
endmodule // aso_tx
`default_nettype wire

//--- src/aso_top.sv
// serial interface with control options, receiver and wishbone registers
`timescale 1ns/10ps
`default_nettype none
module aso_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // serial line
  input  wire logic        rx_pin,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  // interrupt
  output logic             irq
);
  aso_pkg::aso_ctrl_type     ctrl_reg, ctrl_next;
  aso_pkg::aso_fmt_type      fmt;
  aso_pkg::aso_rx_state_type st_reg, st_next;
  logic [15:0] baud_reg, baud_next;
  logic [4:0]  mask_reg, mask_next;
  logic [4:0]  ev_reg, ev_next;
  logic [31:0] dat_reg, dat_next;
  logic        ack_reg, ack_next;
  logic [8:0]  txd_reg, txd_next;
  logic [8:0]  rxd_reg, rxd_next;
  logic        tx_data_empty_flag_reg, tx_data_empty_flag_next;
  logic        tc_reg, tc_next;
  logic        rx_full_flag_reg, rx_full_flag_next;
  logic        ovr_reg, ovr_next;
  logic        idle_reg, idle_next;
  logic        perr_reg, perr_next;
  logic        armed_reg, armed_next;
  logic [3:0]  sub_reg, sub_next;
  logic [3:0]  bit_reg, bit_next;
  logic [9:0]  sh_reg, sh_next;
  logic [7:0]  icnt_reg, icnt_next;
  logic        iarm_reg, iarm_next;
  logic        tick16, tx_busy, tx_line, tx_go;
  logic        req, wr, rd;
  logic        done, keep, wake_addr, idle_hit;
  logic [7:0]  idle_len;
  logic [3:0]  nbits;
  logic [4:0]  flags, irq_en;
  logic [8:0]  rx_word;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  assign fmt      = '{nine: ctrl_reg.data_nine_bits, par_on: ctrl_reg.parity_on,
                      par_odd: ctrl_reg.parity_odd_select};
  assign req      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr       = req && wb_we_i && wb_sel_i[0];
  assign rd       = req && !wb_we_i;
  assign nbits    = ctrl_reg.data_nine_bits ? aso_pkg::BITS_LONG : aso_pkg::BITS_SHORT;
  assign idle_len = ctrl_reg.data_nine_bits ? aso_pkg::IDLE_LONG : aso_pkg::IDLE_SHORT;
  assign flags    = {idle_reg, ovr_reg, rx_full_flag_reg, tc_reg, tx_data_empty_flag_reg};
  assign tx_go    = ctrl_reg.tx_on && !tx_busy && (ctrl_reg.send_break_req || !tx_data_empty_flag_reg);

  aso_baud u_baud (
    .sys_clk (sys_clk),
    .rst     (rst),
    .divisor (baud_reg),
    .tick16  (tick16)
  );

  aso_tx u_tx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick16  (tick16),
    .fmt     (fmt),
    .start   (tx_go),
    .brk     (ctrl_reg.send_break_req),
    .data    (txd_reg),
    .busy    (tx_busy),
    .line    (tx_line)
  );

  // receiver frame engine
  always_comb begin
    st_next  = st_reg;
    sub_next = sub_reg;
    bit_next = bit_reg;
    sh_next  = sh_reg;
    done     = 1'b0;
    if (!ctrl_reg.rx_on) begin
      st_next = aso_pkg::RX_IDLE;
    end else if (tick16) begin
      case (st_reg)
        aso_pkg::RX_IDLE: begin
          if (!rx_pin) begin
            st_next  = aso_pkg::RX_START;
            sub_next = 4'h0;
          end
        end
        aso_pkg::RX_START: begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == aso_pkg::START_MID) begin
            st_next  = rx_pin ? aso_pkg::RX_IDLE : aso_pkg::RX_DATA;
            sub_next = 4'h0;
            bit_next = 4'h0;
          end
        end
        aso_pkg::RX_DATA: begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == aso_pkg::OVERSAMPLE_LAST) begin
            sh_next  = {rx_pin, sh_reg[9:1]};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == nbits - 4'h2) begin
              st_next = aso_pkg::RX_IDLE;
              done    = 1'b1;
            end
          end
        end
        default: st_next = aso_pkg::RX_IDLE;
      endcase
    end
  end

  // shift aligns so stop is bit 9 and last data bit is bit 8
  assign rx_word   = ctrl_reg.data_nine_bits ? sh_next[8:0] : {1'b0, sh_next[8:1]};
  assign wake_addr = ctrl_reg.addr_mark_rouse && sh_next[8];
  assign keep      = done && (!ctrl_reg.rx_sleep || wake_addr);

  // idle line counter
  always_comb begin
    icnt_next = icnt_reg;
    iarm_next = iarm_reg;
    idle_hit  = 1'b0;
    if (!ctrl_reg.rx_on || !rx_pin) begin
      icnt_next = 8'h00;
      iarm_next = iarm_reg || !rx_pin;
    end else if (ctrl_reg.idle_detect_long && st_reg != aso_pkg::RX_IDLE) begin
      icnt_next = 8'h00;
    end else if (tick16) begin
      if (icnt_reg < idle_len) begin
        icnt_next = icnt_reg + 8'h01;
      end else if (iarm_reg) begin
        idle_hit  = 1'b1;
        iarm_next = 1'b0;
      end
    end
  end

  // registers, flags and bus answer
  always_comb begin
    ctrl_next  = ctrl_reg;
    baud_next  = baud_reg;
    mask_next  = mask_reg;
    txd_next   = txd_reg;
    rxd_next   = rxd_reg;
    tx_data_empty_flag_next  = tx_data_empty_flag_reg;
    tc_next    = tc_reg;
    rx_full_flag_next  = rx_full_flag_reg;
    ovr_next   = ovr_reg;
    idle_next  = idle_reg;
    perr_next  = perr_reg;
    armed_next = armed_reg;
    ev_next    = ev_reg;
    dat_next   = 32'h0000_0000;
    ack_next   = req;
    if (rd) begin
      case (wb_adr_i)
        aso_pkg::CTRL_OFF:   dat_next = {19'h00000, ctrl_reg};
        aso_pkg::STATUS_OFF: dat_next = {26'h0000000, perr_reg, flags};
        aso_pkg::DATA_OFF:   dat_next = {23'h000000, rxd_reg};
        aso_pkg::MASK_OFF:   dat_next = {27'h0000000, mask_reg};
        aso_pkg::BAUD_OFF:   dat_next = {16'h0000, baud_reg};
        aso_pkg::EVENT_OFF:  dat_next = {27'h0000000, ev_reg};
        default:             dat_next = 32'h0000_0000;
      endcase
      if (hit(wb_adr_i, aso_pkg::STATUS_OFF)) begin
        armed_next = 1'b1;
      end
      if (hit(wb_adr_i, aso_pkg::EVENT_OFF)) begin
        ev_next = 5'h00;
      end
      if (hit(wb_adr_i, aso_pkg::DATA_OFF) && armed_reg) begin
        rx_full_flag_next  = 1'b0;
        ovr_next   = 1'b0;
        idle_next  = 1'b0;
        perr_next  = 1'b0;
        armed_next = 1'b0;
      end
    end
    if (wr) begin
      if (hit(wb_adr_i, aso_pkg::CTRL_OFF) && wb_sel_i[1]) begin
        ctrl_next = wb_dat_i[12:0];
      end
      if (hit(wb_adr_i, aso_pkg::MASK_OFF)) begin
        mask_next = wb_dat_i[4:0];
      end
      if (hit(wb_adr_i, aso_pkg::BAUD_OFF) && wb_sel_i[1]) begin
        baud_next = wb_dat_i[15:0];
      end
      if (hit(wb_adr_i, aso_pkg::DATA_OFF) && wb_sel_i[1]) begin
        txd_next = wb_dat_i[8:0];
        if (armed_reg) begin
          tx_data_empty_flag_next  = 1'b0;
          tc_next    = 1'b0;
          armed_next = 1'b0;
        end
      end
    end
    // hardware sets come last so they win over clears
    if (tx_go && !ctrl_reg.send_break_req) begin
      tx_data_empty_flag_next = 1'b1;
    end
    if (!tx_busy && !tx_go && tx_data_empty_flag_next) begin
      tc_next = 1'b1;
    end
    if (keep) begin
      if (rx_full_flag_next) begin
        ovr_next = 1'b1;
      end else begin
        rxd_next  = rx_word;
        rx_full_flag_next = 1'b1;
        perr_next = ctrl_reg.parity_on &&
                    ((^rx_word) != ctrl_reg.parity_odd_select);
      end
    end
    if (idle_hit) begin
      idle_next = 1'b1;
    end
    if (idle_hit && !ctrl_reg.addr_mark_rouse) begin
      ctrl_next.rx_sleep = 1'b0;
    end
    if (done && ctrl_reg.rx_sleep && wake_addr) begin
      ctrl_next.rx_sleep = 1'b0;
    end
    ev_next = ev_next | (flags_next_rise(tx_data_empty_flag_next, tc_next, rx_full_flag_next, ovr_next,
                                         idle_next) & ~flags);
  end

  function automatic logic [4:0] flags_next_rise(input logic a, input logic b,
                                                 input logic c, input logic d,
                                                 input logic e);
    flags_next_rise = {e, d, c, b, a};
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= aso_pkg::CTRL_RST;
      baud_reg  <= aso_pkg::BAUD_RST;
      mask_reg  <= aso_pkg::MASK_RST;
      ev_reg    <= 5'h00;
      dat_reg   <= 32'h0000_0000;
      ack_reg   <= 1'b0;
      txd_reg   <= 9'h000;
      rxd_reg   <= 9'h000;
      tx_data_empty_flag_reg  <= 1'b1;
      tc_reg    <= 1'b1;
      rx_full_flag_reg  <= 1'b0;
      ovr_reg   <= 1'b0;
      idle_reg  <= 1'b0;
      perr_reg  <= 1'b0;
      armed_reg <= 1'b0;
      st_reg    <= aso_pkg::RX_IDLE;
      sub_reg   <= 4'h0;
      bit_reg   <= 4'h0;
      sh_reg    <= 10'h000;
      icnt_reg  <= 8'h00;
      iarm_reg  <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      baud_reg  <= baud_next;
      mask_reg  <= mask_next;
      ev_reg    <= ev_next;
      dat_reg   <= dat_next;
      ack_reg   <= ack_next;
      txd_reg   <= txd_next;
      rxd_reg   <= rxd_next;
      tx_data_empty_flag_reg  <= tx_data_empty_flag_next;
      tc_reg    <= tc_next;
      rx_full_flag_reg  <= rx_full_flag_next;
      ovr_reg   <= ovr_next;
      idle_reg  <= idle_next;
      perr_reg  <= perr_next;
      armed_reg <= armed_next;
      st_reg    <= st_next;
      sub_reg   <= sub_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      icnt_reg  <= icnt_next;
      iarm_reg  <= iarm_next;
    end
  end

  assign irq_en = {ctrl_reg.idle_irq_on, ctrl_reg.rx_full_irq_on, ctrl_reg.rx_full_irq_on,
                   ctrl_reg.tx_done_irq_on, ctrl_reg.tx_empty_irq_on};
  assign irq    = |(ev_reg & mask_reg & irq_en);

  assign tx_pin_oe = ctrl_reg.tx_on;
  assign tx_pin_o  = ctrl_reg.tx_on ? tx_line : 1'b1;
  assign wb_dat_o  = dat_reg;
  assign wb_ack_o  = ack_reg;
endmodule // aso_top
`default_nettype wire

//--- tb/aso_monitor.sv
// bus, pin and interrupt checks bound to the serial block
`timescale 1ns/10ps
`default_nettype none
module aso_monitor (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // line and interrupt
  input wire logic        rx_pin,
  input wire logic        tx_pin_o,
  input wire logic        tx_pin_oe,
  input wire logic        irq
);
  logic [12:0] ctrl_reg;
  logic [12:0] ctrl_next;
  // shadow of the control register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
        wb_adr_i == aso_pkg::CTRL_OFF && wb_sel_i[1:0] == 2'h3) begin
      ctrl_next = wb_dat_i[12:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 13'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > aso_pkg::EVENT_OFF |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:13] == 19'h0)
    else $error("upper read bits set");
  a_released_pin_high: assert property (!tx_pin_oe |-> tx_pin_o)
    else $error("released pin not high");
  a_enable_drives_pin: assert property (ctrl_reg[3] == $past(ctrl_reg[3]) |-> tx_pin_oe == ctrl_reg[3])
    else $error("pin enable differs from transmitter enable");
  a_irq_enables_off: assert property (ctrl_reg[7:4] == 4'h0 && $past(ctrl_reg[7:4]) == 4'h0 |-> !irq)
    else $error("interrupt with all enables off");
  a_low_bit_length: assert property ($fell(tx_pin_o) && tx_pin_oe |=> !tx_pin_o [*8])
    else $error("low bit too short");
endmodule // aso_monitor
bind aso_top aso_monitor u_mon (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_pin, .tx_pin_o, .tx_pin_oe, .irq);
`default_nettype wire

//--- tb/aso_line_model.sv
// remote serial partner: frame sender and frame catcher
`timescale 1ns/10ps
`default_nettype none
module aso_line_model (
  // clock
  input  wire logic sys_clk,
  // serial line
  input  wire logic tx_pin_o,
  input  wire logic tx_pin_oe,
  output logic      rx_pin
);
  logic line;
  assign line = tx_pin_oe ? tx_pin_o : 1'b1;
  initial rx_pin = 1'b1;
  // start low, lsb first, stop high, 16 clocks a bit
  task automatic send(input logic [10:0] frame, input int n);
    for (int i = 0; i < n; i++) begin
      rx_pin <= frame[i];
      repeat (16) @(posedge sys_clk);
    end
    rx_pin <= 1'b1;
  endtask
  task automatic grab(output logic [10:0] frame, input int n, output logic seen);
    frame = 11'h7FF;
    seen = 1'b0;
    for (int w = 0; w < 300 && !seen; w++) begin
      @(posedge sys_clk);
      seen = !line;
    end
    if (seen) begin
      repeat (7) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
        frame[i] = line;
        repeat (16) @(posedge sys_clk);
      end
    end
  endtask
endmodule // aso_line_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the serial control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
  logic        sys_clk;
  logic        rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rx_pin;
  logic        tx_pin_o;
  logic        tx_pin_oe;
  logic        irq;
  logic [31:0] rd;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // nine, parity, odd, then nine data bits
  localparam logic [11:0] TX_TAB [4] = '{12'h0A5, 12'h95A, 12'h413, 12'hEC3};
  aso_top dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rx_pin, .tx_pin_o, .tx_pin_oe, .irq);
  aso_line_model pm (.sys_clk, .tx_pin_o, .tx_pin_oe, .rx_pin);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic test_reset;
    `CHK(tx_pin_oe, 1'b0)
    wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
    `CHK(rd, 32'h3)
    wb(1'b0, aso_pkg::MASK_OFF, 32'h0);
    `CHK(rd, 32'h1F)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    $display("reset test done");
  endtask
  task automatic test_tx;
    aso_pkg::aso_ctrl_type c;
    logic [10:0] fr;
    logic [10:0] ex;
    logic [8:0]  pay;
    logic        seen;
    int          w;
    wb(1'b1, aso_pkg::BAUD_OFF, 32'h0);
    c = '0;
    c.tx_on = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    wb(1'b0, aso_pkg::DATA_OFF, 32'h0);
    wb(1'b1, aso_pkg::DATA_OFF, 32'h55);
    pm.grab(fr, 10, seen);
    `CHK(seen, 1'b0)
    for (int k = 0; k < 4; k++) begin
      c.data_nine_bits = TX_TAB[k][11];
      c.parity_on = TX_TAB[k][10];
      c.parity_odd_select = TX_TAB[k][9];
      wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
      w = c.data_nine_bits ? 9 : 8;
      pay = TX_TAB[k][8:0];
      if (c.parity_on) pay[w-1] = ^(pay & ((9'h1 << (w - 1)) - 9'h1)) ^ c.parity_odd_select;
      ex = 11'h7FF;
      ex[0] = 1'b0;
      for (int i = 0; i < w; i++) ex[i+1] = pay[i];
      wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
      wb(1'b1, aso_pkg::DATA_OFF, {23'h0, TX_TAB[k][8:0]});
      pm.grab(fr, w + 2, seen);
      `CHK(fr, ex)
      repeat (20) @(posedge sys_clk);
    end
    wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
    wb(1'b1, aso_pkg::DATA_OFF, 32'h0C3);
    wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
    `CHK(rd[1:0], 2'h1)
    repeat (200) @(posedge sys_clk);
    $display("transmit test done");
  endtask
  task automatic test_break;
    aso_pkg::aso_ctrl_type c;
    logic [10:0] fr;
    logic        seen;
    c = '0;
    c.tx_on = 1'b1;
    c.send_break_req = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    pm.grab(fr, 10, seen);
    `CHK(fr[9:0], 10'h000)
    c.send_break_req = 1'b0;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    repeat (200) @(posedge sys_clk);
    `CHK(pm.line, 1'b1)
    $display("break test done");
  endtask
  task automatic test_irq;
    aso_pkg::aso_ctrl_type c;
    c = '0;
    c.tx_on = 1'b1;
    `CHK(irq, 1'b0)
    c.tx_done_irq_on = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wb(1'b1, aso_pkg::MASK_OFF, 32'h1D);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wb(1'b1, aso_pkg::MASK_OFF, 32'h1F);
    c.tx_done_irq_on = 1'b0;
    c.tx_empty_irq_on = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wb(1'b0, aso_pkg::EVENT_OFF, 32'h0);
    `CHK(rd[1:0], 2'h3)
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    $display("interrupt test done");
  endtask
  task automatic rx_frame(input logic [7:0] d);
    pm.send({2'b11, d, 1'b0}, 10);
    repeat (20) @(posedge sys_clk);
    wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
  endtask
  task automatic test_rx;
    aso_pkg::aso_ctrl_type c;
    c = '0;
    c.rx_on = 1'b1;
    c.rx_full_irq_on = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    rx_frame(8'h3C);
    `CHK(rd[2], 1'b1)
    `CHK(irq, 1'b1)
    wb(1'b0, aso_pkg::DATA_OFF, 32'h0);
    `CHK(rd[8:0], 9'h03C)
    wb(1'b0, aso_pkg::EVENT_OFF, 32'h0);
    c.rx_on = 1'b0;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    rx_frame(8'h5A);
    `CHK(rd[2], 1'b0)
    c.rx_on = 1'b1;
    c.rx_sleep = 1'b1;
    c.addr_mark_rouse = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    rx_frame(8'h11);
    `CHK(rd[2], 1'b0)
    rx_frame(8'h85);
    `CHK(rd[2], 1'b1)
    wb(1'b0, aso_pkg::DATA_OFF, 32'h0);
    `CHK(rd[7:0], 8'h85)
    wb(1'b0, aso_pkg::CTRL_OFF, 32'h0);
    `CHK(rd[1], 1'b0)
    c.addr_mark_rouse = 1'b0;
    c.rx_full_irq_on = 1'b0;
    c.idle_irq_on = 1'b1;
    wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
    wb(1'b0, aso_pkg::EVENT_OFF, 32'h0);
    rx_frame(8'h11);
    repeat (250) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wb(1'b0, aso_pkg::CTRL_OFF, 32'h0);
    `CHK(rd[1], 1'b0)
    $display("receive test done");
  endtask
  task automatic test_rx_modes;
    aso_pkg::aso_ctrl_type c;
    c = '0;
    c.rx_on = 1'b1;
    c.parity_on = 1'b1;
    wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
    wb(1'b0, aso_pkg::DATA_OFF, 32'h0);
    for (int m = 0; m < 2; m++) begin
      c.idle_detect_long = m[0];
      c.data_nine_bits = m[0];
      wb(1'b1, aso_pkg::CTRL_OFF, {19'h0, c});
      pm.send(m ? {1'b1, 9'h1FE, 1'b0} : {2'b11, 8'hFE, 1'b0}, 10 + m);
      repeat (40) @(posedge sys_clk);
      wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
      `CHK(rd[5:4], m ? 2'h0 : 2'h3)
      repeat (150) @(posedge sys_clk);
      wb(1'b0, aso_pkg::STATUS_OFF, 32'h0);
      `CHK(rd[4], 1'b1)
      wb(1'b0, aso_pkg::DATA_OFF, 32'h0);
      `CHK(rd[8:0], m ? 9'h1FE : 9'h0FE)
    end
    $display("receive mode test done");
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_tx();
    test_break();
    test_irq();
    test_rx();
    test_rx_modes();
    conclude();
  end
endmodule // tb
`default_nettype wire
